// [rtl/ckgen_pkg.sv]
`default_nettype none
package ckgen_pkg;
   // ---------------------------------------------------------------
   // register byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CKSEL = 8'h00;
   localparam logic [7:0] ADDR_STSEL = 8'h04;
   localparam logic [7:0] ADDR_STCNT = 8'h08;
   localparam logic [7:0] ADDR_FOSC = 8'h0C;
   localparam logic [7:0] ADDR_SPEED = 8'h10;
   localparam logic [7:0] ADDR_HSOSC = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   // field positions
   localparam int CK_MDIV_LSB = 0;
   localparam int CK_SUBCLOCK_DIVIDE_BIT = 3;
   localparam int CK_MCM_BIT = 4;
   localparam int CK_CSS_BIT = 6;
   localparam int FOSC_EN_BIT = 0;
   localparam int FOSC_SEL_BIT = 1;
   // reset values
   localparam logic [7:0] CKSEL_RST = 8'h00;
   localparam logic [2:0] STSEL_RST = 3'h7;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // timing: clock period, stall and fast oscillator settle wait
   localparam int CLK_NS = 25;
   localparam int STALL_HALF_CYCLES = 281;
   localparam int STALL_CYCLES = (STALL_HALF_CYCLES + 1) / 2;
   localparam int FOSC_WAIT_NS = 100000;
   localparam int FOSC_WAIT_CYC = (FOSC_WAIT_NS + CLK_NS - 1) / CLK_NS;
   // exponent offset of each stabilization step above the shortest one
   function automatic int stab_exp_ofs(input logic [2:0] sel);
      int t [8];
      t = '{0, 1, 2, 3, 5, 7, 9, 10};
      return t[sel];
   endfunction : stab_exp_ofs
endpackage : ckgen_pkg
`default_nettype wire

// [rtl/ckgen_div.sv]
`default_nettype none
// ---------------------------------------------------------------
// power-of-two divider on a source tick
// ---------------------------------------------------------------
module ckgen_div #(
   parameter int W = 6
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // source tick and exponent
   input wire logic tick,
   input wire logic [2:0] div_exp,
   // divided pulse
   output logic pulse
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic pulse;
   } ckgen_div_st_t;
   ckgen_div_st_t s_q, s_d;
   logic [W-1:0] mask;

   // pulse every 2^exp ticks, at most 2^W as the counter wraps; exponent changes take effect mid-count
   always_comb
   begin
      mask = W'((1 << div_exp) - 1);
      s_d = s_q;
      s_d.pulse = 1'b0;
      if (tick)
      begin
         s_d.cnt = W'(s_q.cnt + 1'b1);
         s_d.pulse = ((s_q.cnt & mask) == mask);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end
   assign pulse = s_q.pulse;

   AST_DIV_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
      (div_exp == 3'h0) && tick |=> pulse) else $error("divide by one lost a tick");
endmodule : ckgen_div
`default_nettype wire

// [rtl/ckgen_stab.sv]
`default_nettype none
// ---------------------------------------------------------------
// crystal oscillation stabilization counter
// ---------------------------------------------------------------
module ckgen_stab #(
   parameter int EXP_MIN = 8,
   parameter int CW = 19
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // crystal side
   input wire logic xtal_tick,
   input wire logic restart,
   input wire logic [2:0] sel,
   // status
   output logic [7:0] status,
   output logic done
);
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic [7:0] status;
      logic done;
   } ckgen_stab_st_t;
   ckgen_stab_st_t s_q, s_d;
   logic [CW-1:0] target;

   // count up to the chosen time and then freeze
   always_comb
   begin
      target = CW'(1) << (EXP_MIN + ckgen_pkg::stab_exp_ofs(sel));
      s_d = s_q;
      if (restart)
         s_d = '0;
      else if (xtal_tick && !s_q.done)
         s_d.cnt = CW'(s_q.cnt + 1'b1);
      s_d.done = !restart && (s_d.cnt >= target);
      // thermometer of steps passed, never beyond the chosen step
      for (int i = 0; i < 8; i++)
         s_d.status[7-i] = (i <= sel) &&
            (s_d.cnt >= (CW'(1) << (EXP_MIN + ckgen_pkg::stab_exp_ofs(3'(i)))));
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end
   assign status = s_q.status;
   assign done = s_q.done;

   AST_STAB_FROZEN: assert property (@(posedge aclk) disable iff (!aresetn)
      done && !restart |=> $stable(s_q.cnt)) else $error("counter moved after done");
   AST_STAB_COUNTS: assert property (@(posedge aclk) disable iff (!aresetn)
      xtal_tick && !done && !restart |=> s_q.cnt == $past(s_q.cnt) + 1)
      else $error("tick not counted");
   AST_STAB_NO_OSC: assert property (@(posedge aclk) disable iff (!aresetn)
      restart |=> s_q.cnt == '0 && !done) else $error("counted without oscillation");
   // status was built against last cycle's selection, so a smaller pick lands one cycle late
   AST_STAB_CAPPED: assert property (@(posedge aclk) disable iff (!aresetn)
      (status & (8'hFF >> ($past(sel) + 1))) == 8'h00) else $error("status past chosen time");
endmodule : ckgen_stab
`default_nettype wire

// [rtl/ckgen_top.sv]
`default_nettype none
module ckgen_top #(
   parameter int STAB_EXP_MIN = 8
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // oscillator ticks and state
   input wire logic ihs_tick,
   input wire logic fast_tick,
   input wire logic xtal_tick,
   input wire logic sub_tick,
   input wire logic main_crystal_osc_running,
   input wire logic stop_mode,
   // clock enables and controls
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic rtc_clk_en,
   output logic irq_hold,
   output logic cpu_stall,
   output logic analog_unsafe,
   output logic fast_osc_enable,
   output logic internal_hs_osc_stop
);
   typedef struct packed {
      logic awready, wready, bvalid, arready, rvalid;
      logic have_aw, have_w;
      logic [7:0] awaddr;
      logic [7:0] wdata;
      logic wstrb0;
      logic [1:0] bresp, rresp;
      logic [31:0] rdata;
      logic [7:0] cksel;
      logic [2:0] stsel;
      logic fosc_en, fosc_sel, high_speed_mode_bit, hs_stop;
      logic stall;
      logic [7:0] stall_cnt;
      logic [11:0] fosc_cnt;
      logic fosc_rdy;
      logic cpu_en, per_en, rtc_en, unsafe;
   } ckgen_top_st_t;
   ckgen_top_st_t s_q, s_d;

   logic [7:0] stab_status;
   logic stab_done;
   logic sys_pulse;
   logic src_tick;
   logic [2:0] div_exp;
   logic wr_go;
   logic cpu_source_select;

   // ---------------------------------------------------------------
   // register read decode
   // ---------------------------------------------------------------
   function automatic logic [32:0] rd_decode(input logic [7:0] a, input ckgen_top_st_t s,
                                             input logic [7:0] st, input logic dn);
      if (a == ckgen_pkg::ADDR_CKSEL)
         return {1'b1, 24'h0, s.cksel};
      else if (a == ckgen_pkg::ADDR_STSEL)
         return {1'b1, 29'h0, s.stsel};
      else if (a == ckgen_pkg::ADDR_STCNT)
         return {1'b1, 24'h0, st};
      else if (a == ckgen_pkg::ADDR_FOSC)
         return {1'b1, 30'h0, s.fosc_sel, s.fosc_en};
      else if (a == ckgen_pkg::ADDR_SPEED)
         return {1'b1, 31'h0, s.high_speed_mode_bit};
      else if (a == ckgen_pkg::ADDR_HSOSC)
         return {1'b1, 31'h0, s.hs_stop};
      else if (a == ckgen_pkg::ADDR_STATUS)
         return {1'b1, 28'h0, s.unsafe, s.fosc_rdy, dn, s.stall};
      else
         return {1'b0, 32'h0};
   endfunction : rd_decode

   // ---------------------------------------------------------------
   // clock source selection
   // ---------------------------------------------------------------
   // fast oscillator only counts as selected while it is enabled
   assign cpu_source_select = s_q.cksel[ckgen_pkg::CK_CSS_BIT];
   always_comb
   begin
      if (cpu_source_select)
         src_tick = sub_tick;
      else if (s_q.cksel[ckgen_pkg::CK_MCM_BIT])
         src_tick = xtal_tick;
      else if (s_q.fosc_sel && s_q.fosc_en)
         src_tick = fast_tick;
      else
         src_tick = ihs_tick;
      div_exp = cpu_source_select ? {2'h0, s_q.cksel[ckgen_pkg::CK_SUBCLOCK_DIVIDE_BIT]} :
                      s_q.cksel[ckgen_pkg::CK_MDIV_LSB +: 3];
   end

   ckgen_div #(
      .W(6)
   ) u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(src_tick),
      .div_exp(div_exp),
      .pulse(sys_pulse)
   );

   // counter restarts whenever oscillation is absent or the part sleeps
   ckgen_stab #(
      .EXP_MIN(STAB_EXP_MIN),
      .CW(19)
   ) u_stab (
      .aclk(aclk),
      .aresetn(aresetn),
      .xtal_tick(xtal_tick),
      .restart(stop_mode || !main_crystal_osc_running),
      .sel(s_q.stsel),
      .status(stab_status),
      .done(stab_done)
   );

   // ---------------------------------------------------------------
   // next state: bus slave, registers, stall and enables
   // ---------------------------------------------------------------
   assign wr_go = s_q.have_aw && s_q.have_w && !s_q.bvalid;
   always_comb
   begin
      logic [32:0] rd;
      logic a_hit;
      rd = '0;
      a_hit = 1'b0;
      s_d = s_q;
      // address and data are taken independently, one write at a time
      if (s_axi_awvalid && s_q.awready)
      begin
         s_d.have_aw = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wready)
      begin
         s_d.have_w = 1'b1;
         s_d.wdata = s_axi_wdata[7:0];
         s_d.wstrb0 = s_axi_wstrb[0];
      end
      s_d.awready = !s_d.have_aw && !s_d.bvalid;
      s_d.wready = !s_d.have_w && !s_d.bvalid;
      if (s_axi_bready && s_q.bvalid)
      begin
         s_d.bvalid = 1'b0;
         s_d.awready = !s_d.have_aw;
         s_d.wready = !s_d.have_w;
      end
      // stall runs on system clock pulses, the crystal count keeps going
      if (s_q.stall && sys_pulse)
      begin
         if (s_q.stall_cnt == 8'h00)
            s_d.stall = 1'b0;
         else
            s_d.stall_cnt = s_q.stall_cnt - 8'h01;
      end
      if (wr_go)
      begin
         s_d.have_aw = 1'b0;
         s_d.have_w = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.awready = 1'b0;
         s_d.wready = 1'b0;
         rd = rd_decode(s_q.awaddr, s_q, stab_status, stab_done);
         a_hit = rd[32];
         s_d.bresp = a_hit ? ckgen_pkg::RESP_OKAY : ckgen_pkg::RESP_SLVERR;
         if (s_q.wstrb0)
         begin
            if (s_q.awaddr == ckgen_pkg::ADDR_CKSEL)
               s_d.cksel = s_q.wdata & 8'h5F;
            else if (s_q.awaddr == ckgen_pkg::ADDR_STSEL)
               s_d.stsel = s_q.wdata[2:0];
            else if (s_q.awaddr == ckgen_pkg::ADDR_FOSC)
            begin
               s_d.fosc_en = s_q.wdata[ckgen_pkg::FOSC_EN_BIT];
               s_d.fosc_sel = s_q.wdata[ckgen_pkg::FOSC_SEL_BIT];
            end
            else if (s_q.awaddr == ckgen_pkg::ADDR_SPEED)
            begin
               s_d.high_speed_mode_bit = s_q.wdata[0];
               if (s_q.wdata[0])
               begin
                  s_d.stall = 1'b1;
                  s_d.stall_cnt = 8'(ckgen_pkg::STALL_CYCLES - 1);
               end
            end
            else if (s_q.awaddr == ckgen_pkg::ADDR_HSOSC)
               s_d.hs_stop = s_q.wdata[0];
         end
      end
      // read: address taken, data answered on the next edge
      s_d.arready = !s_d.rvalid;
      if (s_axi_rready && s_q.rvalid)
      begin
         s_d.rvalid = 1'b0;
         s_d.arready = 1'b0;
      end
      if (s_axi_arvalid && s_q.arready)
      begin
         rd = rd_decode(s_axi_araddr, s_q, stab_status, stab_done);
         s_d.rvalid = 1'b1;
         s_d.arready = 1'b0;
         s_d.rdata = rd[31:0];
         s_d.rresp = rd[32] ? ckgen_pkg::RESP_OKAY : ckgen_pkg::RESP_SLVERR;
      end
      // settle timer for the fast oscillator, restarted when it is disabled
      if (!s_q.fosc_en)
      begin
         s_d.fosc_cnt = '0;
         s_d.fosc_rdy = 1'b0;
      end
      else if (s_q.fosc_cnt == 12'(ckgen_pkg::FOSC_WAIT_CYC - 1))
         s_d.fosc_rdy = 1'b1;
      else
         s_d.fosc_cnt = s_q.fosc_cnt + 12'h001;
      // one selected clock drives both CPU and peripherals
      s_d.per_en = sys_pulse;
      s_d.cpu_en = sys_pulse && !s_q.stall;
      s_d.rtc_en = sub_tick;
      s_d.unsafe = cpu_source_select;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_q <= '0;
         s_q.awready <= 1'b1;
         s_q.wready <= 1'b1;
         s_q.arready <= 1'b1;
         s_q.cksel <= ckgen_pkg::CKSEL_RST;
         s_q.stsel <= ckgen_pkg::STSEL_RST;
      end
      else
         s_q <= s_d;
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign s_axi_awready = s_q.awready;
   assign s_axi_wready = s_q.wready;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign s_axi_rvalid = s_q.rvalid;
   assign cpu_clk_en = s_q.cpu_en;
   assign periph_clk_en = s_q.per_en;
   assign rtc_clk_en = s_q.rtc_en;
   assign cpu_stall = s_q.stall;
   // interrupts wait out the stall; the request itself is held upstream
   assign irq_hold = s_q.stall;
   assign analog_unsafe = s_q.unsafe;
   assign fast_osc_enable = s_q.fosc_en;
   assign internal_hs_osc_stop = s_q.hs_stop;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence seq_high_speed_mode_bit_set;
      wr_go && s_q.wstrb0 && (s_q.awaddr == ckgen_pkg::ADDR_SPEED) && s_q.wdata[0];
   endsequence
   sequence seq_css_set;
      wr_go && s_q.wstrb0 && (s_q.awaddr == ckgen_pkg::ADDR_CKSEL) && s_q.wdata[6];
   endsequence

   AST_STALL_START: assert property (@(posedge aclk) disable iff (!aresetn)
      seq_high_speed_mode_bit_set |=> cpu_stall && irq_hold && s_q.stall_cnt == 8'h8C)
      else $error("stall not started at 140 remaining");
   AST_STALL_END: assert property (@(posedge aclk) disable iff (!aresetn)
      cpu_stall && s_q.stall_cnt == 8'h00 && sys_pulse &&
      !(wr_go && s_q.wstrb0 && (s_q.awaddr == ckgen_pkg::ADDR_SPEED) && s_q.wdata[0])
      |=> !cpu_stall) else $error("stall overran");
   AST_STALL_CPU_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
      cpu_stall |=> !cpu_clk_en) else $error("cpu clocked during stall");
   AST_CPU_PERIPH_TIED: assert property (@(posedge aclk) disable iff (!aresetn)
      !cpu_stall |=> cpu_clk_en == periph_clk_en) else $error("cpu and periph differ");
   AST_UNSAFE_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
      seq_css_set |=> ##1 analog_unsafe) else $error("subclock unsafe flag missing");
   AST_BRESP_NEXT: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go |=> s_axi_bvalid) else $error("write answer late");
endmodule : ckgen_top
`default_nettype wire

// [verification/clock_gen_oscillator_control_tb.sv]
`default_nettype none
module clock_gen_oscillator_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int EXPMIN = 2;
   localparam int LIMIT = 20000;
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] d;
      logic [1:0] resp;
      logic [31:0] rd;
   } cgoc_row_t;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   logic ihs_tick, fast_tick, xtal_tick, sub_tick, xtal_run, stop_mode, xtal_on;
   logic cpu_clk_en, periph_clk_en, rtc_clk_en, irq_hold, cpu_stall, analog_unsafe;
   logic fast_osc_enable, internal_hs_osc_stop;
   logic [7:0] tcnt;
   int n_errors, comparisons, cyc, nc, np, nr, ni, nh;
   cgoc_row_t rows [11];
   ckgen_top #(.STAB_EXP_MIN(EXPMIN)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ihs_tick(ihs_tick), .fast_tick(fast_tick), .xtal_tick(xtal_tick), .sub_tick(sub_tick),
      .main_crystal_osc_running(xtal_run), .stop_mode(stop_mode),
      .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .rtc_clk_en(rtc_clk_en),
      .irq_hold(irq_hold), .cpu_stall(cpu_stall), .analog_unsafe(analog_unsafe),
      .fast_osc_enable(fast_osc_enable), .internal_hs_osc_stop(internal_hs_osc_stop));
   // ---------------------------------------------------------------
   // clock, oscillator ticks and watchdog
   // ---------------------------------------------------------------
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   // internal hs every 2nd cycle, fast every cycle, sub every 16th, crystal every 4th
   always @(posedge aclk)
   begin
      tcnt <= tcnt + 8'h01;
      ihs_tick <= tcnt[0];
      fast_tick <= 1'b1;
      sub_tick <= (tcnt[3:0] == 4'h0);
      xtal_tick <= xtal_on && (tcnt[1:0] == 2'h0);
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         n_errors++;
         wrap_up();
      end
   end
   // ---------------------------------------------------------------
   // bus tasks and compares
   // ---------------------------------------------------------------
   task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_val
   task automatic cmp_rng(input string nm, input int lo, input int hi, input int g);
      comparisons++;
      if (g < lo || g > hi)
      begin
         n_errors++;
         $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask : cmp_rng
   // address and data are held until each channel is taken on its own
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hF;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd))
      begin
         @(posedge aclk);
         if (!ad && awready === 1'b1)
         begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready === 1'b1)
         begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : wait_cyc
   // counts clock enables over a window, stall samples only while stalled
   task automatic count_en(input int n, input logic in_stall);
      nc = 0;
      np = 0;
      nr = 0;
      ni = 0;
      nh = 0;
      repeat (n)
      begin
         @(posedge aclk);
         if (in_stall && cpu_stall !== 1'b1)
            break;
         nc += (cpu_clk_en === 1'b1);
         np += (periph_clk_en === 1'b1);
         nr += (rtc_clk_en === 1'b1);
         ni += (ihs_tick === 1'b1);
         nh += (irq_hold !== cpu_stall);
      end
   endtask : count_en
   task automatic wrap_up();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, xtal_run, stop_mode, xtal_on} = 8'h00;
      {ihs_tick, fast_tick, xtal_tick, sub_tick} = 4'h0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'h0;
      tcnt = 8'h00;
      cyc = 0;
      n_errors = 0;
      comparisons = 0;
      rows = '{'{ckgen_pkg::ADDR_CKSEL, 32'hFF, 2'h0, 32'h5F},
               '{ckgen_pkg::ADDR_CKSEL, 32'h00, 2'h0, 32'h00},
               '{ckgen_pkg::ADDR_STSEL, 32'hFF, 2'h0, 32'h07},
               '{ckgen_pkg::ADDR_STSEL, 32'h02, 2'h0, 32'h02},
               '{ckgen_pkg::ADDR_FOSC, 32'h01, 2'h0, 32'h01},
               '{ckgen_pkg::ADDR_FOSC, 32'h00, 2'h0, 32'h00},
               '{ckgen_pkg::ADDR_HSOSC, 32'h01, 2'h0, 32'h01},
               '{ckgen_pkg::ADDR_HSOSC, 32'h00, 2'h0, 32'h00},
               '{ckgen_pkg::ADDR_STCNT, 32'h55, 2'h0, 32'h00},
               '{ckgen_pkg::ADDR_STATUS, 32'hFF, 2'h0, 32'h00},
               '{8'h1C, 32'hFF, ckgen_pkg::RESP_SLVERR, 32'h00}};
      aresetn = 1'b0;
      wait_cyc(20);
      aresetn <= 1'b0;
      @(posedge aclk);
      aresetn <= 1'b1;
      // reset values, stabilization select register at 7
      for (int i = 0; i < 7; i++)
      begin
         axi_rd(8'(4 * i), rd, rs);
         cmp_val("reset value", (i == 1) ? 32'h7 : 32'h0, rd);
      end
      // register rows: write, response, read back
      foreach (rows[i])
      begin
         axi_wr(rows[i].a, rows[i].d, rs);
         cmp_val("bresp", 32'(rows[i].resp), 32'(rs));
         axi_rd(rows[i].a, rd, rs);
         cmp_val("rresp", 32'(rows[i].resp), 32'(rs));
         cmp_val("rdata", rows[i].rd, rd);
         // the oscillator stop bit must also reach its pin
         if (rows[i].a == ckgen_pkg::ADDR_HSOSC)
            cmp_val("hs stop pin", rows[i].rd, 32'(internal_hs_osc_stop));
      end
      // main divider on the internal clock, rtc path unaffected
      for (int n = 0; n < 4; n++)
      begin
         axi_wr(ckgen_pkg::ADDR_CKSEL, 32'(n), rs);
         wait_cyc(20);
         count_en(256, 1'b0);
         cmp_rng("periph pulses", (128 >> n) - 1, (128 >> n) + 1, np);
         cmp_val("cpu vs periph", 32'(np), 32'(nc));
         cmp_rng("rtc pulses", 15, 17, nr);
      end
      axi_wr(ckgen_pkg::ADDR_CKSEL, 32'h0, rs);
      // crystal wait starts only once oscillation exists
      xtal_on <= 1'b1;
      wait_cyc(100);
      axi_rd(ckgen_pkg::ADDR_STCNT, rd, rs);
      cmp_val("stcnt before osc", 32'h00, rd);
      xtal_run <= 1'b1;
      wait_cyc(120);
      axi_rd(ckgen_pkg::ADDR_STCNT, rd, rs);
      cmp_val("stcnt done", 32'hE0, rd);
      axi_rd(ckgen_pkg::ADDR_STATUS, rd, rs);
      cmp_val("status done", 32'h02, rd);
      wait_cyc(300);
      axi_rd(ckgen_pkg::ADDR_STCNT, rd, rs);
      cmp_val("stcnt capped", 32'hE0, rd);
      // stop entry clears, release counts again only to the selected step
      stop_mode <= 1'b1;
      wait_cyc(10);
      axi_rd(ckgen_pkg::ADDR_STCNT, rd, rs);
      cmp_val("stcnt in stop", 32'h00, rd);
      stop_mode <= 1'b0;
      wait_cyc(400);
      axi_rd(ckgen_pkg::ADDR_STCNT, rd, rs);
      cmp_val("stcnt after stop", 32'hE0, rd);
      // stall: restart crystal wait, then set high-speed mode
      stop_mode <= 1'b1;
      wait_cyc(2);
      stop_mode <= 1'b0;
      // stall is up before the write answer is taken; counting starts one edge later
      axi_wr(ckgen_pkg::ADDR_SPEED, 32'h1, rs);
      cmp_val("cpu_stall", 32'h1, 32'(cpu_stall));
      count_en(400, 1'b1);
      cmp_rng("stall clocks", 140, 142, ni);
      cmp_val("cpu pulses in stall", 32'h0, 32'(nc));
      cmp_rng("periph in stall", 139, 142, np);
      cmp_val("irq_hold mismatches", 32'h0, 32'(nh));
      axi_rd(ckgen_pkg::ADDR_STATUS, rd, rs);
      cmp_val("done across stall", 32'h02, rd);
      // fast oscillator: keep internal osc on, wait before selecting
      axi_wr(ckgen_pkg::ADDR_HSOSC, 32'h0, rs);
      axi_wr(ckgen_pkg::ADDR_FOSC, 32'h1, rs);
      cmp_val("fast_osc_enable", 32'h1, 32'(fast_osc_enable));
      axi_rd(ckgen_pkg::ADDR_STATUS, rd, rs);
      cmp_val("fast unsettled", 32'h0, rd & 32'h4);
      wait_cyc(4010);
      axi_rd(ckgen_pkg::ADDR_STATUS, rd, rs);
      cmp_val("fast settled", 32'h4, rd & 32'h4);
      axi_wr(ckgen_pkg::ADDR_FOSC, 32'h3, rs);
      wait_cyc(20);
      count_en(256, 1'b0);
      cmp_rng("fast pulses", 255, 256, np);
      axi_wr(ckgen_pkg::ADDR_FOSC, 32'h0, rs);
      // subclock as source flags the analog and two-wire units
      axi_wr(ckgen_pkg::ADDR_CKSEL, 32'h40, rs);
      wait_cyc(20);
      cmp_val("analog_unsafe", 32'h1, 32'(analog_unsafe));
      count_en(256, 1'b0);
      cmp_rng("sub pulses", 15, 17, np);
      axi_rd(ckgen_pkg::ADDR_STATUS, rd, rs);
      cmp_val("status unsafe", 32'h8, rd & 32'h8);
      axi_wr(ckgen_pkg::ADDR_CKSEL, 32'h00, rs);
      wait_cyc(4);
      cmp_val("analog safe", 32'h0, 32'(analog_unsafe));
      // back on the internal clock, so high-speed mode may be dropped; no stall then
      axi_wr(ckgen_pkg::ADDR_SPEED, 32'h0, rs);
      cmp_val("no stall on clear", 32'h0, 32'(cpu_stall));
      // second reset in mid-run
      axi_wr(ckgen_pkg::ADDR_CKSEL, 32'h12, rs);
      aresetn <= 1'b0;
      wait_cyc(20);
      aresetn <= 1'b1;
      axi_rd(ckgen_pkg::ADDR_CKSEL, rd, rs);
      cmp_val("cksel after reset", 32'h0, rd);
      wrap_up();
   end
endmodule : clock_gen_oscillator_control_tb
`default_nettype wire
